// ---- hdl/alarm_combiner_ack.sv ----
// Alarm combiner with presentation order, acknowledge and hooter output.
`timescale 1ns/100ps
`default_nettype none
// Operation
// R1: Unacknowledged enabled windows raise combined alarm.
// R2: Enabled system error or missing data raise it.
// R3: Network alarm input raises it unconditionally.
// R4: Combined alarm drives network variable and output.
// R5: Several network senders combine as OR.
// R6: Each network sender is a separate module.
// R7: Trigger rising edge enters alarm presentation immediately.
// R8: Repeat interval expiry re-enters alarm presentation.
// R9: Newest first, then ascending window number.
// R10: Key acknowledges shown alarm, advances to next.
// R11: Still-active acknowledged window reappears after repeat.
// R12: All acknowledged returns to cyclic process display.
// R13: Logic or network acknowledge clears all.
// R14: Lost link forces network inputs to zero.
// R15: Polarity passes or inverts the output.
// R16: Nonzero cycle period pulses output during alarm.
// R17: Network variable sent on change, every 6s.
// R18: Combined alarm falls when no source remains.
module alarm_combiner_ack #(
   parameter int unsigned TICK_CYCLES = alarm_pkg::TICK_CYCLES
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Alarm sources
   input wire logic [15:0] window_alarm_trigger_i,
   input wire logic [15:0] window_link_ok_i,
   input wire logic [alarm_pkg::NUM_NET-1:0] network_alarm_input_i,
   input wire logic [alarm_pkg::NUM_NET-1:0] network_link_ok_i,
   input wire logic sys_error_i,
   input wire logic nv_missing_i,
   // Acknowledge sources
   input wire logic key_press_i,
   input wire logic logic_ack_i,
   input wire logic net_ack_i,
   // Alarm outputs
   output logic comb_alarm_nv_o,
   output logic nv_send_o,
   output logic logic_out_o,
   output logic presenting_o,
   output logic [3:0] presented_window_o,
   output logic irq_o
);
   localparam int TW = $clog2(TICK_CYCLES + 1);

   function automatic logic [3:0] first_set(input logic [15:0] v);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 15; i >= 0; i--) begin
         if (v[i]) begin
            r = 4'(i);
         end
      end
      return r;
   endfunction : first_set

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            r[8*b+:8] = d[8*b+:8];
         end
      end
      return r;
   endfunction : merge

   // ****************************************
   // Input synchronisers and edges.
   // ****************************************
   alarm_pkg::pins_t pins_raw;
   alarm_pkg::pins_t s1_reg;
   alarm_pkg::pins_t s2_reg;
   alarm_pkg::pins_t s3_reg;
   logic [15:0] trig;
   logic [15:0] rise;
   logic net_any;
   logic key_edge;
   logic bulk;

   assign pins_raw = {window_alarm_trigger_i, window_link_ok_i, network_alarm_input_i,
                      network_link_ok_i, sys_error_i, nv_missing_i, key_press_i,
                      logic_ack_i, net_ack_i};

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end else begin
         s1_reg <= pins_raw;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // A sender whose link is lost reads as zero, so it cannot trigger an alarm; a window already pending stays pending.
   assign trig = s2_reg.trig & s2_reg.win_ok; // [R14]
   assign rise = trig & ~(s3_reg.trig & s3_reg.win_ok); // [R7]
   assign net_any = |(s2_reg.net & s2_reg.net_ok); // [R5] [R14]
   assign key_edge = s2_reg.key & ~s3_reg.key;
   assign bulk = (s2_reg.lack & ~s3_reg.lack) | (s2_reg.nack & ~s3_reg.nack);

   // ****************************************
   // Register bus.
   // ****************************************
   logic [1:0] ctrl_reg, ctrl_next;
   logic [15:0] win_en_reg, win_en_next;
   logic [6:0] cycle_reg, cycle_next;
   logic [7:0] repeat_reg, repeat_next;
   logic [2:0] mask_reg, mask_next;
   logic [2:0] stat_reg, stat_next;
   logic [2:0] irq_set;
   logic [31:0] dat_reg, dat_next;
   logic ack_reg, ack_next;
   logic irq_reg, irq_next;
   logic go;
   logic [31:0] m;
   logic [15:0] pend_reg;
   logic [3:0] cur_reg;
   alarm_pkg::view_t view_reg;
   logic comb_reg;

   assign go = wb_cyc_i & wb_stb_i & ~ack_reg;

   always_comb begin
      ctrl_next = ctrl_reg;
      win_en_next = win_en_reg;
      cycle_next = cycle_reg;
      repeat_next = repeat_reg;
      mask_next = mask_reg;
      dat_next = 32'h0;
      ack_next = go;
      m = merge(32'h0, wb_dat_i, wb_sel_i);
      if (go && wb_we_i) begin
         case (wb_adr_i)
            alarm_pkg::ADR_CTRL: ctrl_next = 2'(merge({30'h0, ctrl_reg}, wb_dat_i, wb_sel_i));
            alarm_pkg::ADR_WIN_EN: win_en_next = 16'(merge({16'h0, win_en_reg}, wb_dat_i,
                                                           wb_sel_i));
            alarm_pkg::ADR_CYCLE: begin
               m = merge({25'h0, cycle_reg}, wb_dat_i, wb_sel_i);
               cycle_next = (m > {25'h0, alarm_pkg::CYCLE_MAX_SEC}) ?
                            alarm_pkg::CYCLE_MAX_SEC : m[6:0];
            end
            alarm_pkg::ADR_REPEAT: repeat_next = 8'(merge({24'h0, repeat_reg}, wb_dat_i,
                                                          wb_sel_i));
            alarm_pkg::ADR_IRQ_MASK: mask_next = 3'(merge({29'h0, mask_reg}, wb_dat_i,
                                                          wb_sel_i));
            default: begin
            end
         endcase
      end
      if (go && !wb_we_i) begin
         case (wb_adr_i)
            alarm_pkg::ADR_CTRL: dat_next[1:0] = ctrl_reg;
            alarm_pkg::ADR_WIN_EN: dat_next[15:0] = win_en_reg;
            alarm_pkg::ADR_CYCLE: dat_next[6:0] = cycle_reg;
            alarm_pkg::ADR_REPEAT: dat_next[7:0] = repeat_reg;
            alarm_pkg::ADR_STATUS: begin
               dat_next[15:0] = pend_reg;
               dat_next[alarm_pkg::ST_COMB] = comb_reg;
               dat_next[alarm_pkg::ST_PRES] = view_reg[1];
               dat_next[alarm_pkg::ST_CUR+:4] = cur_reg;
            end
            alarm_pkg::ADR_IRQ_STAT: dat_next[2:0] = stat_reg;
            alarm_pkg::ADR_IRQ_MASK: dat_next[2:0] = mask_reg;
            default: dat_next = 32'h0;
         endcase
      end
      // A new event in the cycle of the clearing read survives it.
      stat_next = stat_reg;
      if (go && !wb_we_i && wb_adr_i == alarm_pkg::ADR_IRQ_STAT) begin
         stat_next = 3'h0;
      end
      stat_next = stat_next | irq_set;
      irq_next = |(stat_reg & mask_reg);
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         ctrl_reg <= alarm_pkg::RST_CTRL;
         win_en_reg <= alarm_pkg::RST_WIN_EN;
         cycle_reg <= alarm_pkg::RST_CYCLE;
         repeat_reg <= alarm_pkg::RST_REPEAT;
         mask_reg <= alarm_pkg::RST_MASK;
         stat_reg <= 3'h0;
         dat_reg <= 32'h0;
         ack_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         win_en_reg <= win_en_next;
         cycle_reg <= cycle_next;
         repeat_reg <= repeat_next;
         mask_reg <= mask_next;
         stat_reg <= stat_next;
         dat_reg <= dat_next;
         ack_reg <= ack_next;
         irq_reg <= irq_next;
      end
   end

   // ****************************************
   // Presentation and acknowledge.
   // ****************************************
   logic [TW-1:0] tick_reg, tick_next;
   logic tick;
   logic [7:0] rep_reg, rep_next;
   logic rep_fire;
   logic [15:0] pend_next;
   logic [3:0] cur_next;
   alarm_pkg::view_t view_next;
   logic done;

   assign tick = (tick_reg == TW'(TICK_CYCLES - 1));
   // The repeat clock restarts on every key stroke, so an operator at work is not interrupted.
   // After a key the first second is partial, so at least the full interval always elapses.
   assign rep_fire = tick && (repeat_reg != 8'h00) && (rep_reg >= repeat_reg); // [R8]

   always_comb begin
      tick_next = tick ? '0 : tick_reg + TW'(1);
      rep_next = tick ? rep_reg + 8'h01 : rep_reg;
      if (key_edge) begin
         rep_next = 8'h00;
      end else if (rep_fire) begin
         rep_next = 8'h01;
      end
      pend_next = pend_reg;
      cur_next = cur_reg;
      view_next = view_reg;
      done = 1'b0;
      if (view_reg == alarm_pkg::VIEW_ALARM && key_edge) begin
         pend_next[cur_reg] = 1'b0; // [R10]
      end
      if (bulk) begin
         pend_next = 16'h0000; // [R13]
      end
      if (rep_fire) begin
         pend_next = pend_next | trig; // [R11]
      end
      pend_next = pend_next | rise;
      if (rise != 16'h0000) begin
         view_next = alarm_pkg::VIEW_ALARM; // [R7]
         cur_next = first_set(rise); // [R9]
      end else if (pend_next == 16'h0000) begin
         done = (view_reg == alarm_pkg::VIEW_ALARM);
         view_next = alarm_pkg::VIEW_CYCLIC; // [R12]
      end else if (rep_fire || view_reg == alarm_pkg::VIEW_ALARM) begin
         view_next = alarm_pkg::VIEW_ALARM; // [R8]
         if (rep_fire || key_edge || !pend_next[cur_reg]) begin
            cur_next = first_set(pend_next); // [R9] [R10]
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         tick_reg <= '0;
         rep_reg <= 8'h00;
         pend_reg <= 16'h0000;
         cur_reg <= 4'h0;
         view_reg <= alarm_pkg::VIEW_CYCLIC;
      end else begin
         tick_reg <= tick_next;
         rep_reg <= rep_next;
         pend_reg <= pend_next;
         cur_reg <= cur_next;
         view_reg <= view_next;
      end
   end

   // ****************************************
   // Combined alarm and outputs.
   // ****************************************
   logic comb_next;
   logic [2:0] send_reg, send_next;
   logic send_due;
   logic nv_send_reg, nv_send_next;
   logic [6:0] phase_reg, phase_next;
   logic pulse_on;
   logic lout_reg, lout_next;

   assign send_due = tick && (send_reg == alarm_pkg::SEND_MAX_SEC - 3'h1);
   assign pulse_on = {1'b0, phase_reg} < (({1'b0, cycle_reg} + 8'h01) >> 1);

   always_comb begin
      comb_next = (|(pend_reg & win_en_reg)) // [R1]
                  | (ctrl_reg[alarm_pkg::CTRL_SYS] & (s2_reg.sys_err | s2_reg.nv_miss)) // [R2]
                  | net_any; // [R3] [R18]
      nv_send_next = (comb_next != comb_reg) | send_due; // [R17]
      send_next = nv_send_next ? 3'h0 : (tick ? send_reg + 3'h1 : send_reg);
      phase_next = phase_reg;
      if (!comb_reg || cycle_reg == 7'h00) begin
         phase_next = 7'h00;
      end else if (tick) begin
         phase_next = (phase_reg >= cycle_reg - 7'h01) ? 7'h00 : phase_reg + 7'h01; // [R16]
      end
      lout_next = (comb_reg & ((cycle_reg == 7'h00) | pulse_on)) // [R4] [R16]
                  ^ ctrl_reg[alarm_pkg::CTRL_INV]; // [R15]
      irq_set = 3'h0;
      irq_set[alarm_pkg::IRQ_NEW] = (rise != 16'h0000);
      irq_set[alarm_pkg::IRQ_COMB] = comb_next & ~comb_reg;
      irq_set[alarm_pkg::IRQ_DONE] = done;
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         comb_reg <= 1'b0;
         send_reg <= 3'h0;
         nv_send_reg <= 1'b0;
         phase_reg <= 7'h00;
         lout_reg <= 1'b0;
      end else begin
         comb_reg <= comb_next;
         send_reg <= send_next;
         nv_send_reg <= nv_send_next;
         phase_reg <= phase_next;
         lout_reg <= lout_next;
      end
   end

   assign wb_dat_o = dat_reg;
   assign wb_ack_o = ack_reg;
   assign irq_o = irq_reg;
   assign comb_alarm_nv_o = comb_reg; // [R4]
   assign nv_send_o = nv_send_reg;
   assign logic_out_o = lout_reg;
   assign presenting_o = view_reg[1];
   assign presented_window_o = cur_reg;

   // ****************************************
   // Checks.
   // ****************************************
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!reset_n_i);

   win_alarm_a: assert property ((|(pend_reg & win_en_reg)) |=> comb_reg) // [R1]
      else $error("enabled pending window did not raise combined alarm");
   sys_alarm_a: assert property ((ctrl_reg[1] && (s2_reg.sys_err || s2_reg.nv_miss))
      |=> comb_reg) // [R2]
      else $error("system error did not raise combined alarm");
   net_alarm_a: assert property (net_any |=> comb_reg) // [R3] [R5]
      else $error("network alarm did not raise combined alarm");
   comb_clear_a: assert property ((!net_any && (pend_reg & win_en_reg) == 16'h0 &&
      !(ctrl_reg[1] && (s2_reg.sys_err || s2_reg.nv_miss))) |=> !comb_reg) // [R18]
      else $error("combined alarm stuck without source");
   new_entry_a: assert property ((rise != 16'h0) |=> view_reg == alarm_pkg::VIEW_ALARM &&
      cur_reg == first_set($past(rise))) // [R7] [R9]
      else $error("new alarm not presented first");
   repeat_show_a: assert property ((rep_fire && trig != 16'h0) |=>
      view_reg == alarm_pkg::VIEW_ALARM && (pend_reg & $past(trig)) != 16'h0) // [R8] [R11]
      else $error("active window not re-presented after repeat");
   key_ack_a: assert property ((view_reg[1] && key_edge && !bulk && rise == 16'h0 &&
      !rep_fire) |=> !pend_reg[$past(cur_reg)]) // [R10]
      else $error("key did not acknowledge presented alarm");
   all_done_a: assert property ((view_reg[1] && key_edge && rise == 16'h0 && !rep_fire &&
      pend_reg == (16'h0001 << cur_reg)) |=> view_reg[0]) // [R12]
      else $error("no return to cyclic display");
   bulk_ack_a: assert property ((bulk && rise == 16'h0 && !rep_fire) |=> pend_reg == 16'h0)
      // [R13]
      else $error("bulk acknowledge left alarms pending");
   link_lost_a: assert property ((view_reg[0] && s2_reg.win_ok == 16'h0) |=> view_reg[0])
      // [R14]
      else $error("window with lost link triggered presentation");
   level_out_a: assert property ((cycle_reg == 7'h00) |=>
      logic_out_o == ($past(comb_reg) ^ $past(ctrl_reg[0]))) // [R15]
      else $error("logic output level or polarity wrong");
   quiet_out_a: assert property ((!comb_reg) |=> logic_out_o == $past(ctrl_reg[0])) // [R16]
      else $error("logic output active without alarm");
   send_change_a: assert property ($changed(comb_reg) |-> nv_send_o) // [R4] [R17]
      else $error("combined alarm change not sent");
   send_cycle_a: assert property (send_due |=> nv_send_o) // [R17]
      else $error("periodic send overdue");
   send_range_a: assert property (send_reg <= 3'h5) // [R17]
      else $error("send interval counter out of range");
endmodule : alarm_combiner_ack
`default_nettype wire

// ---- hdl/alarm_pkg.sv ----
// Constants and carrier types for the alarm combiner.
package alarm_pkg;
   localparam int NUM_WIN = 16;
   localparam int NUM_NET = 4;
   localparam int CLK_PERIOD_NS = 20;
   localparam int SEC_NS = 1000000000;
   localparam int TICK_CYCLES = SEC_NS / CLK_PERIOD_NS;
   localparam logic [2:0] SEND_MAX_SEC = 3'h6;
   localparam logic [6:0] CYCLE_MAX_SEC = 7'h64;
   // ****************************************
   // Register map, byte addresses.
   // ****************************************
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_WIN_EN = 8'h04;
   localparam logic [7:0] ADR_CYCLE = 8'h08;
   localparam logic [7:0] ADR_REPEAT = 8'h0c;
   localparam logic [7:0] ADR_STATUS = 8'h10;
   localparam logic [7:0] ADR_IRQ_STAT = 8'h14;
   localparam logic [7:0] ADR_IRQ_MASK = 8'h18;
   localparam int CTRL_INV = 0;
   localparam int CTRL_SYS = 1;
   localparam int ST_COMB = 16;
   localparam int ST_PRES = 17;
   localparam int ST_CUR = 18;
   localparam int IRQ_NEW = 0;
   localparam int IRQ_COMB = 1;
   localparam int IRQ_DONE = 2;
   localparam logic [1:0] RST_CTRL = 2'h0;
   localparam logic [15:0] RST_WIN_EN = 16'h0000;
   localparam logic [6:0] RST_CYCLE = 7'h00;
   localparam logic [7:0] RST_REPEAT = 8'h3c;
   localparam logic [2:0] RST_MASK = 3'h0;
   typedef struct packed {
      logic [NUM_WIN-1:0] trig;
      logic [NUM_WIN-1:0] win_ok;
      logic [NUM_NET-1:0] net;
      logic [NUM_NET-1:0] net_ok;
      logic sys_err;
      logic nv_miss;
      logic key;
      logic lack;
      logic nack;
   } pins_t;
   typedef enum logic [1:0] {
      VIEW_CYCLIC = 2'b01,
      VIEW_ALARM = 2'b10
   } view_t;
endpackage : alarm_pkg

// ---- verif/net_sender_model.sv ----
// Behavioural model of the network modules that send alarms to the combiner.
`timescale 1ns/100ps
`default_nettype none
module net_sender_model (
   // Clock
   input wire logic ref_clk_i,
   // Bench commands
   input wire logic [alarm_pkg::NUM_NET-1:0] level_i,
   input wire logic [alarm_pkg::NUM_NET-1:0] link_i,
   // Towards the combiner
   output logic [alarm_pkg::NUM_NET-1:0] alarm_o,
   output logic [alarm_pkg::NUM_NET-1:0] link_ok_o
);
   logic [alarm_pkg::NUM_NET-1:0] junk_reg = '0;
   always_ff @(posedge ref_clk_i) begin
      junk_reg <= ~junk_reg;
   end
   // Every bit stands for a module of its own, each with an alarm line and a link flag.
   // A lost sender leaves its line wandering, so only the link flag can mask it.
   always_comb begin
      for (int i = 0; i < alarm_pkg::NUM_NET; i++) begin
         alarm_o[i] = link_i[i] ? level_i[i] : junk_reg[i];
      end
      link_ok_o = link_i;
   end
endmodule : net_sender_model
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking bench for the alarm combiner.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic ref_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic ack, comb, send, lout, pres, irq;
   logic [3:0] cur;
   logic [3:0] want = 4'h0;
   logic [3:0] link = 4'hf;
   logic [3:0] net, net_ok;
   alarm_pkg::pins_t pins = '0;
   logic [31:0] exp_q[$];
   int n_fail = 0;
   int check_count = 0;
   int cyc_n = 0;
   int seed = 92;
   int cnt, sends, idx;
   logic [31:0] r;
   always #10 ref_clk_i = ~ref_clk_i;
   alarm_combiner_ack #(.TICK_CYCLES(10)) alarm_combiner_ack_inst (
      .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hf), .wb_dat_o(rdat),
      .wb_ack_o(ack), .window_alarm_trigger_i(pins.trig), .window_link_ok_i(pins.win_ok),
      .network_alarm_input_i(net), .network_link_ok_i(net_ok), .sys_error_i(pins.sys_err),
      .nv_missing_i(pins.nv_miss), .key_press_i(pins.key), .logic_ack_i(pins.lack),
      .net_ack_i(pins.nack), .comb_alarm_nv_o(comb), .nv_send_o(send), .logic_out_o(lout),
      .presenting_o(pres), .presented_window_o(cur), .irq_o(irq));
   net_sender_model net_sender_model_inst (.ref_clk_i(ref_clk_i), .level_i(want),
      .link_i(link), .alarm_o(net), .link_ok_o(net_ok));
   task automatic check(input logic [31:0] seen, input logic [31:0] expv);
      check_count++;
      if (seen !== expv) begin
         n_fail++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, expv);
      end
   endtask : check
   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : tally_and_finish
   // Holds the request until ack is seen at a rising edge, then drops it.
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      if (!w) exp_q.push_back(d);
      @(posedge ref_clk_i);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= w ? d : 32'h0;
      do @(posedge ref_clk_i); while (ack !== 1'b1 && ++k < 50);
      if (k >= 50) begin
         n_fail++;
         tally_and_finish();
      end
      cyc <= 1'b0;
   endtask : wb
   task automatic tk(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask : tk
   task automatic set_trig(input logic [15:0] v);
      @(posedge ref_clk_i);
      pins.trig <= v;
      tk(5);
   endtask : set_trig
   task automatic hit(input int src);
      @(posedge ref_clk_i);
      if (src == 0) pins.key <= 1'b1;
      if (src == 1) pins.lack <= 1'b1;
      if (src == 2) pins.nack <= 1'b1;
      tk(3);
      @(posedge ref_clk_i);
      pins.key <= 1'b0;
      pins.lack <= 1'b0;
      pins.nack <= 1'b0;
      tk(4);
   endtask : hit
   // Read data is compared against the oldest note whenever a read answer shows up.
   always @(posedge ref_clk_i) begin
      if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) check(rdat, exp_q.pop_front());
   end
   always @(posedge ref_clk_i) begin
      cyc_n++;
      if (cyc_n == 20000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   initial begin
      pins.win_ok = 16'hffff;
      repeat (20) @(posedge ref_clk_i);
      reset_n_i <= 1'b1;
      wb(1'b0, alarm_pkg::ADR_CTRL, 32'(alarm_pkg::RST_CTRL));
      wb(1'b0, alarm_pkg::ADR_WIN_EN, 32'(alarm_pkg::RST_WIN_EN));
      wb(1'b0, alarm_pkg::ADR_CYCLE, 32'(alarm_pkg::RST_CYCLE));
      wb(1'b0, alarm_pkg::ADR_REPEAT, 32'(alarm_pkg::RST_REPEAT));
      wb(1'b0, alarm_pkg::ADR_IRQ_MASK, 32'(alarm_pkg::RST_MASK));
      wb(1'b0, 8'h1c, 32'h0);
      r = $random(seed);
      wb(1'b1, alarm_pkg::ADR_WIN_EN, r);
      wb(1'b0, alarm_pkg::ADR_WIN_EN, {16'h0, r[15:0]});
      wb(1'b1, alarm_pkg::ADR_CYCLE, 32'hc8);
      wb(1'b0, alarm_pkg::ADR_CYCLE, 32'h64);
      wb(1'b1, alarm_pkg::ADR_CYCLE, 32'h0);
      wb(1'b1, alarm_pkg::ADR_REPEAT, 32'h0);
      wb(1'b1, alarm_pkg::ADR_WIN_EN, 32'h0);
      $display("registers done");
      idx = $unsigned($random(seed)) % 4;
      want[idx] <= 1'b1;
      tk(8);
      check(comb, 1'b1);
      check(lout, 1'b1);
      link[idx] <= 1'b0;
      tk(8);
      check(comb, 1'b0);
      link <= 4'hf;
      want <= 4'h0;
      tk(8);
      check(comb, 1'b0);
      $display("network done");
      wb(1'b1, alarm_pkg::ADR_WIN_EN, 32'h0210);
      wb(1'b1, alarm_pkg::ADR_IRQ_MASK, 32'h1);
      set_trig(16'h0200);
      check(pres, 1'b1);
      check(cur, 4'h9);
      check(comb, 1'b1);
      check(irq, 1'b1);
      wb(1'b1, alarm_pkg::ADR_STATUS, 32'h0);
      wb(1'b0, alarm_pkg::ADR_STATUS, 32'h00270200);
      set_trig(16'h0210);
      check(cur, 4'h4);
      wb(1'b0, alarm_pkg::ADR_IRQ_STAT, 32'h3);
      tk(2);
      check(irq, 1'b0);
      hit(0);
      check(cur, 4'h9);
      check(pres, 1'b1);
      hit(0);
      check(pres, 1'b0);
      check(comb, 1'b0);
      $display("presentation done");
      for (int s = 1; s < 3; s++) begin
         set_trig(16'h0);
         set_trig(16'h0210);
         check(pres, 1'b1);
         hit(s);
         check(pres, 1'b0);
         check(comb, 1'b0);
      end
      set_trig(16'h0);
      $display("bulk acknowledge done");
      wb(1'b1, alarm_pkg::ADR_CTRL, 32'h2);
      pins.sys_err <= 1'b1;
      tk(5);
      check(comb, 1'b1);
      wb(1'b1, alarm_pkg::ADR_CTRL, 32'h0);
      tk(5);
      check(comb, 1'b0);
      pins.sys_err <= 1'b0;
      wb(1'b1, alarm_pkg::ADR_CTRL, 32'h2);
      pins.nv_miss <= 1'b1;
      tk(5);
      check(comb, 1'b1);
      pins.nv_miss <= 1'b0;
      wb(1'b1, alarm_pkg::ADR_CTRL, 32'h1);
      tk(5);
      check(lout, 1'b1);
      $display("system error and polarity done");
      wb(1'b1, alarm_pkg::ADR_CTRL, 32'h0);
      wb(1'b1, alarm_pkg::ADR_CYCLE, 32'h2);
      want <= 4'h1;
      tk(10);
      cnt = 0;
      sends = 0;
      repeat (70) begin
         tk(1);
         cnt += (lout === 1'b1);
         sends += (send === 1'b1);
      end
      check(cnt > 20 && cnt < 50, 1'b1);
      check(sends > 0, 1'b1);
      want <= 4'h0;
      wb(1'b1, alarm_pkg::ADR_CYCLE, 32'h0);
      $display("pulse and send done");
      wb(1'b1, alarm_pkg::ADR_REPEAT, 32'h1);
      set_trig(16'h0080);
      check(cur, 4'h7);
      hit(0);
      check(pres, 1'b0);
      cnt = 0;
      while (pres !== 1'b1 && cnt < 40) begin
         tk(1);
         cnt++;
      end
      check(pres, 1'b1);
      check(cur, 4'h7);
      set_trig(16'h0);
      wb(1'b1, alarm_pkg::ADR_REPEAT, 32'h0);
      hit(0);
      $display("repeat done");
      pins.win_ok <= 16'h0;
      set_trig(16'h0400);
      check(pres, 1'b0);
      set_trig(16'h0);
      pins.win_ok <= 16'hffff;
      tk(4);
      check(pres, 1'b0);
      $display("window link done");
      tally_and_finish();
   end
endmodule : testbench
`default_nettype wire
